// *** verilog/mcr_params.svh ***
`ifndef MCR_PARAMS_SVH
`define MCR_PARAMS_SVH
// host port addresses
`define MCR_PORT_STAGE0      3'h0
`define MCR_PORT_STAGE1      3'h1
`define MCR_PORT_STAGE2      3'h2
`define MCR_PORT_STAGE3      3'h3
`define MCR_PORT_LOAD        3'h4
`define MCR_PORT_RDIDX       3'h5
`define MCR_PORT_MEMADDR     3'h6
// control word indices
`define MCR_IDX_MEMCTL       5'h00
`define MCR_IDX_CONFIG       5'h01
`define MCR_IDX_FIFOIO       5'h02
// reset values and writable masks
`define MCR_MEMCTL_RESET     8'h00
`define MCR_MEMCTL_MASK      8'h7F
`define MCR_CONFIG_RESET     32'h0000_602B
`define MCR_FIFOIO_RESET     32'h0000_0000
`define MCR_FIFOIO_MASK      32'hFFFC_0000
// memory access control fields
`define MCR_MC_AUTOINC       6
`define MCR_MC_DIR           5
`define MCR_MC_SEL           4:2
`define MCR_MC_WSEL          1:0
// device configuration fields
`define MCR_CFG_COUNT        31:16
`define MCR_CFG_CNTMODE      15
`define MCR_CFG_FASTDAC      14
`define MCR_CFG_FINALBYP     13
`define MCR_CFG_HALFTAP      12
`define MCR_CFG_INTERP       11:10
`define MCR_CFG_WIDTH        9:6
`define MCR_CFG_SINCBYP      5
`define MCR_CFG_HBEN         4
`define MCR_CFG_SHAPEBYP     3
`define MCR_CFG_DEC2         2
`define MCR_CFG_MAPBYP       1
`define MCR_CFG_FIFOBYP      0
// fifo and io control fields
`define MCR_FIO_FREQ         31:24
`define MCR_FIO_STOPFULL     23
`define MCR_FIO_EMPTYZERO    22
`define MCR_FIO_THRMODE      21:20
`define MCR_FIO_TXZERO       19
`define MCR_FIO_WRUNGATED    18
// memory select codes
`define MCR_SEL_NONE         3'h0
`define MCR_SEL_ICOEF        3'h1
`define MCR_SEL_QCOEF        3'h2
`define MCR_SEL_IQCOEF       3'h3
`define MCR_SEL_MAP          3'h4
`define MCR_SEL_FIFO         3'h5
// interpolation codes and factors
`define MCR_INTERP_4X        2'h0
`define MCR_INTERP_8X        2'h1
`define MCR_INTERP_16X       2'h2
`define MCR_FACTOR_4X        5'h04
`define MCR_FACTOR_8X        5'h08
`define MCR_FACTOR_16X       5'h10
`define MCR_FACTOR_NONE      5'h00
`endif

// *** verilog/mcr_pkg.sv ***
package mcr_pkg;
  typedef logic [31:0] mcr_word_type;
  typedef logic [7:0]  mcr_byte_type;
  typedef enum logic [1:0] {THR_OFF, THR_PLAIN, THR_FREQ, THR_LAG} mcr_thresh_type;
endpackage : mcr_pkg

// *** verilog/mcr_config_registers.sv ***
`timescale 1ns/1ns
`include "mcr_params.svh"
module mcr_config_registers #(
  parameter int SAMPLE_W = 16
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                ce,
  // host byte port
  input  wire logic                hostWrite,
  input  wire logic                hostRead,
  input  wire logic [2:0]          hostAddr,
  input  wire logic [7:0]          hostDataBusIn,
  output      logic [7:0]          hostDataBusOut,
  output      logic                hostDataBusOe,
  // memory access control
  input  wire logic                memWordDone,
  output      logic [7:0]          memAddr,
  output      logic [1:0]          memWordSelect,
  output      logic                memRead,
  output      logic                memWrite,
  output      logic                iCoeffMemorySel,
  output      logic                qCoeffMemorySel,
  output      logic                constMapSel,
  output      logic                fifoMemSel,
  // datapath configuration
  output      logic [15:0]         symbolCountLimit,
  output      logic                symbolCounterMode,
  output      logic                fastDacDelay,
  output      logic                finalInterpBypass,
  output      logic                halfTapMode,
  output      logic [4:0]          interpFactor,
  output      logic [5:0]          symbolBitCount,
  output      logic                sincCompBypass,
  output      logic                halfBandEnable,
  output      logic                shapingBypass,
  output      logic                shapingDecimate,
  output      logic                constMapBypass,
  output      logic                inputFifoBypass,
  // fifo threshold control
  output      logic [7:0]          fifoFreqTerm,
  output      logic                thresholdEnable,
  output      logic                fifoFlagEnable,
  output      logic                modifyFreqError,
  output      logic                forceLagLimit,
  // fifo write path
  input  wire logic                transmitEnablePin,
  input  wire logic                fifoFull,
  input  wire logic                fifoEmpty,
  input  wire logic                fifoReadsGated,
  input  wire logic [SAMPLE_W-1:0] sampleInData,
  input  wire logic                sampleInValid,
  output      logic                sampleInReady,
  output      logic [SAMPLE_W-1:0] fifoWriteData,
  output      logic                fifoWriteValid,
  input  wire logic                fifoWriteReady,
  // fifo read path
  input  wire logic [SAMPLE_W-1:0] fifoReadData,
  output      logic [SAMPLE_W-1:0] fifoBlockData
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [5:0] bitCount(input logic [3:0] code, input logic doubled);
    logic [5:0] base;
    base = {2'h0, code} + 6'h01;
    return doubled ? {base[4:0], 1'h0} : base;
  endfunction : bitCount

  function automatic logic [4:0] factorOf(input logic [1:0] code);
    case (code)
      `MCR_INTERP_4X:  return `MCR_FACTOR_4X;
      `MCR_INTERP_8X:  return `MCR_FACTOR_8X;
      `MCR_INTERP_16X: return `MCR_FACTOR_16X;
      default:         return `MCR_FACTOR_NONE;
    endcase
  endfunction : factorOf

  ////////////////////////////////////////////////////////////////////////////
  // host port and control words

  mcr_pkg::mcr_word_type staging_r, staging_nxt;
  mcr_pkg::mcr_word_type config_r, config_nxt;
  mcr_pkg::mcr_word_type fifoIo_r, fifoIo_nxt;
  mcr_pkg::mcr_byte_type memCtl_r, memCtl_nxt;
  logic [4:0]            readIdx_r, readIdx_nxt;
  logic [7:0]            memAddr_r, memAddr_nxt;
  logic [7:0]            readByte_r, readByte_nxt;
  logic                  readOe_r, readOe_nxt;
  mcr_pkg::mcr_word_type readWord;
  logic                  loadStrobe;

  assign loadStrobe = hostWrite && (hostAddr == `MCR_PORT_LOAD);

  always_comb begin
    staging_nxt  = staging_r;
    config_nxt   = config_r;
    fifoIo_nxt   = fifoIo_r;
    memCtl_nxt   = memCtl_r;
    readIdx_nxt  = readIdx_r;
    memAddr_nxt  = memAddr_r;
    readWord     = 32'h0000_0000;
    if (hostWrite) begin
      case (hostAddr)
        `MCR_PORT_STAGE0:  staging_nxt[7:0]   = hostDataBusIn;
        `MCR_PORT_STAGE1:  staging_nxt[15:8]  = hostDataBusIn;
        `MCR_PORT_STAGE2:  staging_nxt[23:16] = hostDataBusIn;
        `MCR_PORT_STAGE3:  staging_nxt[31:24] = hostDataBusIn;
        `MCR_PORT_RDIDX:   readIdx_nxt        = hostDataBusIn[4:0];
        `MCR_PORT_MEMADDR: memAddr_nxt        = hostDataBusIn;
        default: ;
      endcase
    end
    if (loadStrobe) begin
      case (hostDataBusIn[4:0])
        `MCR_IDX_MEMCTL: memCtl_nxt = staging_r[7:0] & `MCR_MEMCTL_MASK;
        `MCR_IDX_CONFIG: config_nxt = staging_r;
        `MCR_IDX_FIFOIO: fifoIo_nxt = staging_r & `MCR_FIFOIO_MASK;
        default: ;
      endcase
    end
    // host address load wins over an increment in the same cycle
    if (memWordDone && memCtl_r[`MCR_MC_AUTOINC] &&
        !(hostWrite && hostAddr == `MCR_PORT_MEMADDR)) begin
      memAddr_nxt = memAddr_r + 8'h01;
    end
    case (readIdx_r)
      `MCR_IDX_MEMCTL: readWord = {24'h00_0000, memCtl_r};
      `MCR_IDX_CONFIG: readWord = config_r;
      `MCR_IDX_FIFOIO: readWord = fifoIo_r;
      default:         readWord = 32'h0000_0000;
    endcase
    readOe_nxt = hostRead;
    case (hostAddr)
      `MCR_PORT_STAGE0: readByte_nxt = readWord[7:0];
      `MCR_PORT_STAGE1: readByte_nxt = readWord[15:8];
      `MCR_PORT_STAGE2: readByte_nxt = readWord[23:16];
      `MCR_PORT_STAGE3: readByte_nxt = readWord[31:24];
      default:          readByte_nxt = 8'h00;
    endcase
    if (!hostRead) begin
      readByte_nxt = readByte_r;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      staging_r  <= 32'h0000_0000;
      config_r   <= `MCR_CONFIG_RESET;
      fifoIo_r   <= `MCR_FIFOIO_RESET;
      memCtl_r   <= `MCR_MEMCTL_RESET;
      readIdx_r  <= 5'h00;
      memAddr_r  <= 8'h00;
      readByte_r <= 8'h00;
      readOe_r   <= 1'h0;
    end else if (ce) begin
      staging_r  <= staging_nxt;
      config_r   <= config_nxt;
      fifoIo_r   <= fifoIo_nxt;
      memCtl_r   <= memCtl_nxt;
      readIdx_r  <= readIdx_nxt;
      memAddr_r  <= memAddr_nxt;
      readByte_r <= readByte_nxt;
      readOe_r   <= readOe_nxt;
    end
  end

  assign hostDataBusOut = readByte_r;
  assign hostDataBusOe  = readOe_r;

  ////////////////////////////////////////////////////////////////////////////
  // decoded controls

  logic [2:0]             memSel;
  logic                   memSelValid;
  mcr_pkg::mcr_thresh_type thrMode;

  assign memSel        = memCtl_r[`MCR_MC_SEL];
  // undefined select codes act as no access
  assign memSelValid   = (memSel != `MCR_SEL_NONE) && (memSel <= `MCR_SEL_FIFO);
  assign memAddr       = memAddr_r;
  assign memWordSelect = memCtl_r[`MCR_MC_WSEL];
  assign memRead       = memSelValid && memCtl_r[`MCR_MC_DIR];
  assign memWrite      = memSelValid && !memCtl_r[`MCR_MC_DIR];
  assign iCoeffMemorySel = (memSel == `MCR_SEL_ICOEF) || (memSel == `MCR_SEL_IQCOEF);
  assign qCoeffMemorySel = (memSel == `MCR_SEL_QCOEF) || (memSel == `MCR_SEL_IQCOEF);
  assign constMapSel   = (memSel == `MCR_SEL_MAP);
  assign fifoMemSel    = (memSel == `MCR_SEL_FIFO);

  assign symbolCountLimit  = config_r[`MCR_CFG_COUNT];
  assign symbolCounterMode = config_r[`MCR_CFG_CNTMODE];
  assign fastDacDelay      = config_r[`MCR_CFG_FASTDAC];
  assign finalInterpBypass = config_r[`MCR_CFG_FINALBYP];
  assign halfTapMode       = config_r[`MCR_CFG_HALFTAP];
  assign interpFactor      = factorOf(config_r[`MCR_CFG_INTERP]);
  assign symbolBitCount    = bitCount(config_r[`MCR_CFG_WIDTH], config_r[`MCR_CFG_HALFTAP]);
  assign sincCompBypass    = config_r[`MCR_CFG_SINCBYP];
  assign halfBandEnable    = config_r[`MCR_CFG_HBEN];
  assign shapingBypass     = config_r[`MCR_CFG_SHAPEBYP];
  assign shapingDecimate   = config_r[`MCR_CFG_DEC2];
  assign constMapBypass    = config_r[`MCR_CFG_MAPBYP];
  assign inputFifoBypass   = config_r[`MCR_CFG_FIFOBYP];

  assign fifoFreqTerm    = fifoIo_r[`MCR_FIO_FREQ];
  assign thrMode         = mcr_pkg::mcr_thresh_type'(fifoIo_r[`MCR_FIO_THRMODE]);
  assign thresholdEnable = (thrMode != mcr_pkg::THR_OFF);
  assign fifoFlagEnable  = (thrMode != mcr_pkg::THR_OFF);
  assign modifyFreqError = (thrMode == mcr_pkg::THR_FREQ);
  assign forceLagLimit   = (thrMode == mcr_pkg::THR_LAG);

  ////////////////////////////////////////////////////////////////////////////
  // two-entry buffer in front of the fifo write port

  logic [SAMPLE_W-1:0] slot_r [2];
  logic [SAMPLE_W-1:0] slot_nxt [2];
  logic                wrPtr_r, wrPtr_nxt;
  logic                rdPtr_r, rdPtr_nxt;
  logic [1:0]          count_r, count_nxt;
  logic                writeAllow;
  logic                push;
  logic                pop;

  // stalled writes hold the word here and back-pressure the source
  assign writeAllow = !(fifoIo_r[`MCR_FIO_STOPFULL] && fifoFull) &&
                      (fifoIo_r[`MCR_FIO_WRUNGATED] || transmitEnablePin);
  assign sampleInReady  = (count_r != 2'h2);
  assign fifoWriteValid = (count_r != 2'h0) && writeAllow;
  assign fifoWriteData  = slot_r[rdPtr_r];
  assign push = sampleInValid && sampleInReady;
  assign pop  = fifoWriteValid && fifoWriteReady;

  always_comb begin
    slot_nxt[0] = slot_r[0];
    slot_nxt[1] = slot_r[1];
    wrPtr_nxt   = wrPtr_r;
    rdPtr_nxt   = rdPtr_r;
    count_nxt   = count_r;
    if (push) begin
      slot_nxt[wrPtr_r] = sampleInData;
      wrPtr_nxt         = !wrPtr_r;
    end
    if (pop) begin
      rdPtr_nxt = !rdPtr_r;
    end
    case ({push, pop})
      2'h2:    count_nxt = count_r + 2'h1;
      2'h1:    count_nxt = count_r - 2'h1;
      default: count_nxt = count_r;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      slot_r[0] <= '0;
      slot_r[1] <= '0;
      wrPtr_r   <= 1'h0;
      rdPtr_r   <= 1'h0;
      count_r   <= 2'h0;
    end else if (ce) begin
      slot_r[0] <= slot_nxt[0];
      slot_r[1] <= slot_nxt[1];
      wrPtr_r   <= wrPtr_nxt;
      rdPtr_r   <= rdPtr_nxt;
      count_r   <= count_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifo read data with zero forcing

  logic [SAMPLE_W-1:0] blockData_r, blockData_nxt;
  logic                forceZero;

  assign forceZero = (fifoIo_r[`MCR_FIO_EMPTYZERO] && fifoEmpty) ||
                     (fifoIo_r[`MCR_FIO_TXZERO] && fifoReadsGated && !transmitEnablePin);

  always_comb begin
    blockData_nxt = forceZero ? '0 : fifoReadData;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      blockData_r <= '0;
    end else if (ce) begin
      blockData_r <= blockData_nxt;
    end
  end

  assign fifoBlockData = blockData_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_AUTOINC: assert property (@(posedge clk) disable iff (reset)
    ce && memWordDone && memCtl_r[`MCR_MC_AUTOINC] && !(hostWrite && hostAddr == `MCR_PORT_MEMADDR)
    |=> memAddr == $past(memAddr) + 8'h01)
    else $error("memory address did not advance");

  AST_NOINC: assert property (@(posedge clk) disable iff (reset)
    ce && !memCtl_r[`MCR_MC_AUTOINC] && !(hostWrite && hostAddr == `MCR_PORT_MEMADDR) |=> $stable(memAddr))
    else $error("memory address moved without auto increment");

  AST_DIR: assert property (@(posedge clk) disable iff (reset)
    memSelValid |-> (memRead == memCtl_r[`MCR_MC_DIR]) && (memWrite != memRead))
    else $error("memory direction wrong");

  AST_NOSEL: assert property (@(posedge clk) disable iff (reset)
    !memSelValid |-> !(memRead || memWrite || iCoeffMemorySel || qCoeffMemorySel || constMapSel || fifoMemSel))
    else $error("access active without valid select");

  AST_LOAD: assert property (@(posedge clk) disable iff (reset)
    ce && loadStrobe && hostDataBusIn[4:0] == `MCR_IDX_CONFIG |=> config_r == $past(staging_r))
    else $error("staging word not transferred");

  AST_STAGE_READ: assert property (@(posedge clk) disable iff (reset)
    ce && hostWrite && hostAddr == `MCR_PORT_STAGE3 ##1 ce && hostWrite && hostAddr == `MCR_PORT_LOAD
    && hostDataBusIn[4:0] == `MCR_IDX_FIFOIO |=> fifoIo_r[`MCR_FIO_FREQ] == $past(hostDataBusIn, 2))
    else $error("staged byte lost");

  AST_RESET_CFG: assert property (@(posedge clk) disable iff (reset)
    $past(reset) |-> finalInterpBypass && sincCompBypass && shapingBypass && constMapBypass
    && inputFifoBypass && !halfBandEnable && !symbolCounterMode && symbolCountLimit == 16'h0000)
    else $error("configuration reset value wrong");

  AST_INTERP: assert property (@(posedge clk) disable iff (reset)
    interpFactor == ((config_r[`MCR_CFG_INTERP] == `MCR_INTERP_4X) ? `MCR_FACTOR_4X :
                     (config_r[`MCR_CFG_INTERP] == `MCR_INTERP_8X) ? `MCR_FACTOR_8X :
                     (config_r[`MCR_CFG_INTERP] == `MCR_INTERP_16X) ? `MCR_FACTOR_16X : `MCR_FACTOR_NONE))
    else $error("interpolation factor wrong");

  AST_WIDTH: assert property (@(posedge clk) disable iff (reset)
    symbolBitCount == (halfTapMode ? ({2'h0, config_r[`MCR_CFG_WIDTH]} + 6'h01) * 6'h02
                                   : {2'h0, config_r[`MCR_CFG_WIDTH]} + 6'h01))
    else $error("symbol bit count wrong");

  AST_FULLSTOP: assert property (@(posedge clk) disable iff (reset)
    fifoIo_r[`MCR_FIO_STOPFULL] && fifoFull |-> !fifoWriteValid)
    else $error("fifo written while full");

  AST_WRGATE: assert property (@(posedge clk) disable iff (reset)
    !fifoIo_r[`MCR_FIO_WRUNGATED] && !transmitEnablePin |-> !fifoWriteValid)
    else $error("fifo write not gated by transmit enable");

  AST_EMPTYZERO: assert property (@(posedge clk) disable iff (reset)
    ce && fifoIo_r[`MCR_FIO_EMPTYZERO] && fifoEmpty |=> fifoBlockData == '0)
    else $error("empty fifo data not zeroed");

  AST_TXZERO: assert property (@(posedge clk) disable iff (reset)
    ce && fifoIo_r[`MCR_FIO_TXZERO] && fifoReadsGated && !transmitEnablePin |=> fifoBlockData == '0)
    else $error("gated fifo data not zeroed");

  AST_HOLD: assert property (@(posedge clk) disable iff (reset)
    fifoWriteValid && !fifoWriteReady && ce && writeAllow |=> (count_r != 2'h0) && $stable(fifoWriteData))
    else $error("stalled word lost");

endmodule : mcr_config_registers

// *** verification/mcr_host_model.sv ***
`timescale 1ns/1ns
module mcr_host_model (
  // clock
  input  wire logic       clk,
  // host byte port
  output      logic       hostWrite,
  output      logic       hostRead,
  output      logic [2:0] hostAddr,
  output      logic [7:0] hostDataBusIn,
  input  wire logic [7:0] hostDataBusOut,
  input  wire logic       hostDataBusOe
);
  initial begin
    hostWrite = 1'h0;
    hostRead = 1'h0;
    hostAddr = 3'h7;
    hostDataBusIn = 8'h00;
  end
  task automatic cycle(input logic wr, input logic rd, input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    hostWrite = wr;
    hostRead = rd;
    hostAddr = a;
    hostDataBusIn = d;
  endtask : cycle
  // released bus shows the inverse of its last byte
  task automatic idle;
    cycle(1'h0, 1'h0, hostAddr, ~hostDataBusIn);
  endtask : idle
  task automatic wr1(input logic [2:0] a, input logic [7:0] d);
    cycle(1'h1, 1'h0, a, d);
    idle();
  endtask : wr1
  task automatic put_word(input logic [4:0] idx, input logic [31:0] w);
    for (int i = 0; i < 4; i++) cycle(1'h1, 1'h0, i[2:0], w[8*i +: 8]);
    cycle(1'h1, 1'h0, 3'h4, {3'h0, idx});
    idle();
  endtask : put_word
  task automatic get_word(input logic [4:0] idx, output logic [31:0] w, output logic oe);
    oe = 1'h1;
    cycle(1'h1, 1'h0, 3'h5, {3'h0, idx});
    for (int i = 0; i < 4; i++) begin
      cycle(1'h0, 1'h1, i[2:0], ~hostDataBusIn);
      idle();
      w[8*i +: 8] = hostDataBusOut;
      oe = oe & hostDataBusOe;
    end
  endtask : get_word
endmodule : mcr_host_model

// *** verification/mcr_config_registers_bench.sv ***
`timescale 1ns/1ns
module mcr_config_registers_bench;
  typedef struct packed {logic [31:0] w; logic [4:0] f; logic [5:0] n;} mcr_row_type;
  logic        clk = 1'h0, reset = 1'h1, ce = 1'h1, memWordDone = 1'h0, v, oe;
  logic        hostWrite, hostRead, hostDataBusOe, memRead, memWrite, sampleInReady, fifoWriteValid;
  logic        iCoeffMemorySel, qCoeffMemorySel, constMapSel, fifoMemSel, symbolCounterMode, fastDacDelay;
  logic        finalInterpBypass, halfTapMode, sincCompBypass, halfBandEnable, shapingBypass, shapingDecimate;
  logic        constMapBypass, inputFifoBypass, thresholdEnable, fifoFlagEnable, modifyFreqError, forceLagLimit;
  logic        transmitEnablePin = 1'h0, fifoFull = 1'h0, fifoEmpty = 1'h0, fifoReadsGated = 1'h0;
  logic        sampleInValid = 1'h0, fifoWriteReady = 1'h1;
  logic [1:0]  memWordSelect;
  logic [2:0]  hostAddr;
  logic [4:0]  interpFactor;
  logic [5:0]  symbolBitCount;
  logic [7:0]  hostDataBusIn, hostDataBusOut, memAddr, fifoFreqTerm;
  logic [15:0] symbolCountLimit, fifoWriteData, fifoBlockData, sampleInData = 16'h0000, fifoReadData = 16'h1234;
  logic [31:0] rdw;
  int          err_total = 0, n_checks = 0;
  mcr_row_type rows [4] = '{'{32'hFFFF_8000, 5'h04, 6'h01}, '{32'h0001_17D5, 5'h08, 6'h20},
                            '{32'h1234_2BEA, 5'h10, 6'h10}, '{32'h0000_5C80, 5'h00, 6'h06}};
  always #4 clk = ~clk;
  mcr_config_registers #(.SAMPLE_W(16)) dut (.clk, .reset, .ce, .hostWrite, .hostRead, .hostAddr, .hostDataBusIn,
    .hostDataBusOut, .hostDataBusOe, .memWordDone, .memAddr, .memWordSelect, .memRead, .memWrite,
    .iCoeffMemorySel, .qCoeffMemorySel, .constMapSel, .fifoMemSel, .symbolCountLimit, .symbolCounterMode,
    .fastDacDelay, .finalInterpBypass, .halfTapMode, .interpFactor, .symbolBitCount, .sincCompBypass,
    .halfBandEnable, .shapingBypass, .shapingDecimate, .constMapBypass, .inputFifoBypass, .fifoFreqTerm,
    .thresholdEnable, .fifoFlagEnable, .modifyFreqError, .forceLagLimit, .transmitEnablePin, .fifoFull,
    .fifoEmpty, .fifoReadsGated, .sampleInData, .sampleInValid, .sampleInReady, .fifoWriteData,
    .fifoWriteValid, .fifoWriteReady, .fifoReadData, .fifoBlockData);
  mcr_host_model host (.clk, .hostWrite, .hostRead, .hostAddr, .hostDataBusIn, .hostDataBusOut, .hostDataBusOe);
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'h1) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic reset_check;
    reset = 1'h1;
    step(5);
    reset = 1'h0;
    host.get_word(5'h00, rdw, oe);
    chk(rdw[7:0] === 8'h00 && oe === 1'h1, "memctl reset");
    host.get_word(5'h01, rdw, oe);
    chk(rdw === 32'h0000_602B, "config reset");
    chk(interpFactor === 5'h04 && symbolBitCount === 6'h01 && finalInterpBypass === 1'h1, "config out");
    host.get_word(5'h02, rdw, oe);
    chk(rdw === 32'h0000_0000 && fifoFreqTerm === 8'h00, "fifo reset");
  endtask : reset_check
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_check();
    foreach (rows[i]) begin
      host.put_word(5'h01, rows[i].w);
      host.get_word(5'h01, rdw, oe);
      chk(rdw === rows[i].w, "config readback");
      chk({symbolCountLimit, symbolCounterMode, fastDacDelay, finalInterpBypass, halfTapMode}
          === rows[i].w[31:12], "config upper");
      chk({sincCompBypass, halfBandEnable, shapingBypass, shapingDecimate, constMapBypass, inputFifoBypass}
          === rows[i].w[5:0], "config lower");
      chk(interpFactor === rows[i].f && symbolBitCount === rows[i].n, "interp or width");
    end
    for (int s = 0; s < 8; s++) begin
      host.put_word(5'h00, {24'h00_0000, 1'h1, 1'h0, s[0], s[2:0], 2'h3});
      host.get_word(5'h00, rdw, oe);
      chk(rdw[7:0] === {2'h0, s[0], s[2:0], 2'h3}, "memctl readback");
      v = s inside {[1:5]};
      chk({iCoeffMemorySel, qCoeffMemorySel, constMapSel, fifoMemSel}
          === {s == 1 || s == 3, s == 2 || s == 3, s == 4, s == 5}, "select decode");
      chk({memRead, memWrite, memWordSelect} === {v & s[0], v & ~s[0], 2'h3}, "direction");
    end
    host.put_word(5'h00, 32'h0000_0040);
    host.wr1(3'h6, 8'hFF);
    chk(memAddr === 8'hFF, "address load");
    memWordDone = 1'h1;
    step(2);
    memWordDone = 1'h0;
    step(1);
    chk(memAddr === 8'h01, "increment wrap");
    host.put_word(5'h00, 32'h0000_0000);
    memWordDone = 1'h1;
    step(1);
    memWordDone = 1'h0;
    step(1);
    chk(memAddr === 8'h01, "no increment");
    for (int m = 0; m < 4; m++) begin
      host.put_word(5'h02, {8'hA5, 2'h3, m[1:0], 20'hF_FFFF});
      host.get_word(5'h02, rdw, oe);
      chk(rdw === {8'hA5, 2'h3, m[1:0], 2'h3, 18'h0_0000} && fifoFreqTerm === 8'hA5, "fifo word");
      chk({thresholdEnable, fifoFlagEnable, modifyFreqError, forceLagLimit}
          === {m != 0, m != 0, m == 2, m == 3}, "threshold mode");
    end
    for (int k = 0; k < 32; k++) begin
      host.put_word(5'h02, {8'h00, 1'h0, k[4], 2'h0, k[3], 19'h0_0000});
      {fifoEmpty, fifoReadsGated, transmitEnablePin} = k[2:0];
      step(2);
      chk(fifoBlockData === (((k[4] & k[2]) | (k[3] & k[1] & ~k[0])) ? 16'h0000 : 16'h1234), "read path");
    end
    // gated writes: fill to refusal, stall, then drain
    transmitEnablePin = 1'h0;
    sampleInData = 16'h0A01;
    sampleInValid = 1'h1;
    step(1);
    sampleInData = 16'h0A02;
    step(1);
    sampleInData = 16'h0A03;
    step(1);
    chk(sampleInReady === 1'h0 && fifoWriteValid === 1'h0, "full and gated");
    transmitEnablePin = 1'h1;
    fifoWriteReady = 1'h0;
    step(2);
    chk(fifoWriteValid === 1'h1 && fifoWriteData === 16'h0A01, "stalled head");
    fifoWriteReady = 1'h1;
    step(1);
    chk(fifoWriteData === 16'h0A02, "second word");
    step(1);
    sampleInValid = 1'h0;
    chk(fifoWriteData === 16'h0A03, "third word");
    step(1);
    chk(fifoWriteValid === 1'h0, "drained");
    host.put_word(5'h02, 32'h0084_0000);
    transmitEnablePin = 1'h0;
    fifoFull = 1'h1;
    sampleInData = 16'h0A04;
    sampleInValid = 1'h1;
    step(1);
    sampleInValid = 1'h0;
    fifoWriteReady = 1'h0;
    step(1);
    chk(fifoWriteValid === 1'h0, "stop on full");
    fifoFull = 1'h0;
    #1;
    chk(fifoWriteValid === 1'h1 && fifoWriteData === 16'h0A04, "ungated write");
    fifoWriteReady = 1'h1;
    step(1);
    ce = 1'h0;
    host.put_word(5'h01, 32'hFFFF_FFFF);
    ce = 1'h1;
    chk(symbolCountLimit === 16'h0000 && halfBandEnable === 1'h0, "ce low freezes");
    reset_check();
    wrap_up();
  end
  // run needs about 600 cycles; allow many more
  initial begin
    #400_000;
    err_total++;
    wrap_up();
  end
endmodule : mcr_config_registers_bench
